// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the IN endpoint against a queue model.
// Assumes: Registers driven over the plain strobe port, host model on the link.
// Notes: Packets are checked byte by byte against the queue of written bytes.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock;
  logic reset;
  usb_in_pkg::reg_req_t regReq;
  logic [15:0] regRdata;
  logic epEnable;
  logic inToken;
  logic ackRcvd;
  logic noAck;
  usb_in_pkg::tx_byte_t txOut;
  usb_in_pkg::handshake_t handshake;
  logic inIrq;
  int miscompares;
  int checks_done;
  int seed;
  int pidExp;
  logic [15:0] ctl;
  logic [15:0] rd;
  logic [7:0] expQ[$];

  usb_in_endpoint dut (.clock(clock), .reset(reset), .regReq(regReq), .regRdata(regRdata),
    .epEnable(epEnable), .inToken(inToken), .ackRcvd(ackRcvd), .noAck(noAck),
    .txOut(txOut), .handshake(handshake), .inIrq(inIrq));
  usb_host_model host (.clock(clock), .txOut(txOut), .handshake(handshake), .inIrq(inIrq),
    .inToken(inToken), .ackRcvd(ackRcvd), .noAck(noAck));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", name, e, g);
      miscompares++;
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    regReq <= '0;
  endtask

  task automatic rreg(input logic [3:0] a);
    @(posedge clock);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clock);
    regReq <= '0;
    #1;
    rd = regRdata;
  endtask

  task automatic chkFill(input logic [15:0] e);
    rreg(usb_in_pkg::OFF_CTRL);
    chk("fill", e, {14'h0000, rd[usb_in_pkg::FILL_LSB +: 2]});
  endtask

  task automatic ready();
    wreg(usb_in_pkg::OFF_CTRL, ctl | (16'h0001 << usb_in_pkg::READY_BIT));
  endtask

  task automatic setLayout(input int s, input int l, input int d, input int c);
    logic [15:0] v;
    v = 16'((s << usb_in_pkg::START_LSB) | (l << usb_in_pkg::LEN_LSB));
    v = v | 16'((d << usb_in_pkg::DBL_BIT) | (c << usb_in_pkg::CONT_BIT));
    wreg(usb_in_pkg::OFF_LAYOUT, v);
    rreg(usb_in_pkg::OFF_LAYOUT);
    chk("layout", v, rd);
  endtask

  task automatic putBytes(input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      expQ.push_back(b);
      wreg(usb_in_pkg::OFF_DATA, {8'h00, b});
    end
  endtask

  // Bytes stay queued until acknowledged, so a resend is checked against the same bytes.
  task automatic inTx(input logic doAck, input int kind, input int len);
    host.transact(doAck, $unsigned($random(seed)) % 4);
    chk("kind", 16'(kind), 16'(host.rxKind));
    if (kind == 2) begin
      chk("length", 16'(len), 16'(host.rxLen));
      chk("pid", 16'(pidExp), {15'h0000, host.rxPid});
      chk("irq", {15'h0000, doAck}, {15'h0000, host.rxIrq});
      for (int i = 0; i < len; i++) begin
        chk("byte", {8'h00, expQ[i]}, {8'h00, host.rxBytes[i]});
      end
      if (doAck) begin
        repeat (len) void'(expQ.pop_front());
        pidExp = 1 - pidExp;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Whole run needs a few hundred cycles; twenty thousand means a hang.
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    conclude();
  end

  initial begin
    reset = 1'b1;
    regReq = '0;
    epEnable = 1'b0;
    seed = 32'h32247317;
    pidExp = 0;
    ctl = 16'h0000;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    rreg(usb_in_pkg::OFF_MAX_PKT);
    chk("maxpkt", usb_in_pkg::MAX_PKT_RESET, rd);
    chkFill(16'h0003);
    rreg(4'h2);
    chk("unmapped", 16'h0000, rd);
    @(posedge clock);
    epEnable <= 1'b1;
    repeat (3) @(posedge clock);
    chkFill(16'h0000);
    // Isochronous setting keeps the feedback select clear; bulk clears both again.
    wreg(usb_in_pkg::OFF_CTRL, 16'h0001 << usb_in_pkg::PERIODIC_BIT);
    rreg(usb_in_pkg::OFF_CTRL);
    chk("ctrl", 16'h0001 << usb_in_pkg::PERIODIC_BIT, rd & 16'h003c);
    wreg(usb_in_pkg::OFF_CTRL, ctl);
    rreg(usb_in_pkg::OFF_CTRL);
    chk("ctrl", 16'h0000, rd & 16'h003c);
    wreg(usb_in_pkg::OFF_MAX_PKT, 16'h0008);
    rreg(usb_in_pkg::OFF_MAX_PKT);
    chk("maxpkt", 16'h0008, rd);
    setLayout(1, 1, 0, 0);
    inTx(1'b1, 0, 0);
    putBytes(5);
    ready();
    chkFill(16'h0003);
    wreg(usb_in_pkg::OFF_DATA, 16'h00aa);
    inTx(1'b0, 2, 5);
    chkFill(16'h0003);
    inTx(1'b1, 2, 5);
    chkFill(16'h0000);
    ready();
    inTx(1'b1, 2, 0);
    putBytes(3);
    ready();
    wreg(usb_in_pkg::OFF_CTRL, 16'h0001 << usb_in_pkg::HALT_BIT);
    inTx(1'b1, 1, 0);
    wreg(usb_in_pkg::OFF_CTRL, ctl);
    inTx(1'b1, 2, 3);
    wreg(usb_in_pkg::OFF_CTRL, 16'h0001 << usb_in_pkg::SEQRST_BIT);
    pidExp = 0;
    putBytes(2);
    ready();
    inTx(1'b1, 2, 2);
    setLayout(4, 1, 1, 0);
    putBytes(4);
    ready();
    chkFill(16'h0001);
    putBytes(6);
    ready();
    chkFill(16'h0003);
    inTx(1'b1, 2, 4);
    chkFill(16'h0001);
    inTx(1'b1, 2, 6);
    chkFill(16'h0000);
    setLayout(8, 1, 0, 0);
    ctl = 16'h0001 << usb_in_pkg::AUTO_BIT;
    wreg(usb_in_pkg::OFF_CTRL, ctl);
    putBytes(8);
    chkFill(16'h0003);
    inTx(1'b1, 2, 8);
    putBytes(3);
    chkFill(16'h0000);
    ready();
    chkFill(16'h0003);
    inTx(1'b1, 2, 3);
    ctl = 16'h0000;
    wreg(usb_in_pkg::OFF_CTRL, ctl);
    setLayout(16, 1, 0, 1);
    putBytes(20);
    ready();
    chkFill(16'h0003);
    inTx(1'b1, 2, 8);
    inTx(1'b0, 2, 8);
    inTx(1'b1, 2, 8);
    chkFill(16'h0003);
    inTx(1'b1, 2, 4);
    chkFill(16'h0000);
    inTx(1'b1, 0, 0);
    conclude();
  end
endmodule
`default_nettype wire

// ---- bench/usb_host_model.sv ----
// Purpose: Host side of the IN endpoint: issues IN tokens and answers data packets.
// Assumes: One clock; the device answers within 200 cycles of the token.
// Notes: Results are left in rx* variables for the bench to read.
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
  // Clock.
  input wire logic clock,
  // Device answers.
  input wire usb_in_pkg::tx_byte_t txOut,
  input wire usb_in_pkg::handshake_t handshake,
  input wire logic inIrq,
  // Host requests.
  output logic inToken,
  output logic ackRcvd,
  output logic noAck
);
  logic [7:0] rxBytes [0:63];
  int rxLen;
  int rxKind;
  logic rxPid;
  logic rxIrq;

  initial begin
    inToken = 1'b0;
    ackRcvd = 1'b0;
    noAck = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Kind: 0 NAK, 1 STALL, 2 data, -1 nothing. A slow host waits gap cycles to answer.
  task automatic transact(input logic doAck, input int gap);
    logic fin;
    fin = 1'b0;
    rxKind = -1;
    rxLen = 0;
    rxPid = 1'b0;
    rxIrq = 1'b0;
    @(posedge clock);
    inToken <= 1'b1;
    @(posedge clock);
    inToken <= 1'b0;
    for (int t = 0; t < 200 && !fin; t++) begin
      @(posedge clock);
      if (handshake.valid === 1'b1) begin
        rxKind = (handshake.stall === 1'b1) ? 1 : 0;
        fin = 1'b1;
      end
      if (txOut.valid === 1'b1) begin
        rxKind = 2;
        rxPid = txOut.pidData1;
        if (txOut.empty !== 1'b1 && rxLen < 64) begin
          rxBytes[rxLen] = txOut.data;
          rxLen++;
        end
        fin = (txOut.last === 1'b1);
      end
    end
    if (rxKind == 2) begin
      repeat (gap) @(posedge clock);
      ackRcvd <= doAck;
      noAck <= !doAck;
      @(posedge clock);
      ackRcvd <= 1'b0;
      noAck <= 1'b0;
      repeat (4) begin
        @(posedge clock);
        if (inIrq === 1'b1) begin
          rxIrq = 1'b1;
        end
      end
    end
  endtask
endmodule
`default_nettype wire

// ---- hdl/fill_tracker.sv ----
// Purpose: Fill-state flags and buffer selectors of the IN FIFO.
// Assumes: Prepare is never raised while full; sent only while a packet is held.
// Notes: A prepare and a send in the same cycle leave the count unchanged.
`timescale 1ns/100ps
`default_nettype none
module fill_tracker (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Events.
  input wire logic dbl,
  input wire logic enRise,
  input wire logic ptrInit,
  input wire logic prepare,
  input wire logic sent,
  // State.
  output logic [1:0] fill,
  output logic wrBuf,
  output logic rdBuf
);
  always_ff @(posedge clock) begin
    if (reset) begin
      fill <= usb_in_pkg::FILL_FULL;
    end else if (enRise) begin
      fill <= usb_in_pkg::FILL_EMPTY;
    end else begin
      case ({prepare, sent})
        2'b10: begin
          if (fill == usb_in_pkg::FILL_EMPTY) begin
            fill <= dbl ? usb_in_pkg::FILL_ONE : usb_in_pkg::FILL_FULL;
          end else begin
            fill <= usb_in_pkg::FILL_FULL;
          end
        end
        2'b01: begin
          if (fill == usb_in_pkg::FILL_FULL && dbl) begin
            fill <= usb_in_pkg::FILL_ONE;
          end else begin
            fill <= usb_in_pkg::FILL_EMPTY;
          end
        end
        default: begin
          fill <= fill;
        end
      endcase
    end
  end

  // Buffer selectors alternate only in double buffer mode.
  always_ff @(posedge clock) begin
    if (reset || enRise || ptrInit) begin
      wrBuf <= 1'b0;
      rdBuf <= 1'b0;
    end else begin
      if (prepare && dbl) begin
        wrBuf <= ~wrBuf;
      end
      if (sent && dbl) begin
        rdBuf <= ~rdBuf;
      end
    end
  end
endmodule
`default_nettype wire

// ---- hdl/in_buffer_ram.sv ----
// Purpose: Byte-wide shared buffer memory with one write and one read port.
// Assumes: Single clock; read data is registered.
// Notes: Read data appear one cycle after the read address.
`timescale 1ns/100ps
`default_nettype none
module in_buffer_ram #(
  parameter int DEPTH = usb_in_pkg::MEM_BYTES,
  parameter int AW = usb_in_pkg::ADDR_W
) (
  // Clock.
  input wire logic clock,
  // Write port.
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  // Read port.
  input wire logic [AW-1:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wrEn && (int'(wrAddr) < DEPTH)) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clock) begin
    rdData <= (int'(rdAddr) < DEPTH) ? mem[rdAddr] : 8'h00;
  end
endmodule
`default_nettype wire

// ---- hdl/usb_in_endpoint.sv ----
// Purpose: Transmit side of one USB IN endpoint: registers, FIFO fill and IN answers.
// Assumes: Token, ACK and timeout strobes come from logic on the same clock.
// Notes: One byte leaves per cycle; the link side must accept it without stalling.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module usb_in_endpoint (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Register port.
  input wire usb_in_pkg::reg_req_t regReq,
  output logic [15:0] regRdata,
  // Link side.
  input wire logic epEnable,
  input wire logic inToken,
  input wire logic ackRcvd,
  input wire logic noAck,
  output usb_in_pkg::tx_byte_t txOut,
  output usb_in_pkg::handshake_t handshake,
  output logic inIrq
);
  localparam int AW = usb_in_pkg::ADDR_W;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10
  } tx_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Address helpers.

  function automatic logic [AW-1:0] bufAddr(input logic [AW-1:0] base,
                                            input logic [AW-1:0] size,
                                            input logic idx,
                                            input logic [AW-1:0] off);
    bufAddr = base + (idx ? size : {AW{1'b0}}) + off;
  endfunction

  function automatic logic [AW-1:0] minLen(input logic [15:0] mps,
                                           input logic [AW-1:0] rest);
    if (mps[15:AW] != '0 || mps[AW-1:0] >= rest) begin
      minLen = rest;
    end else begin
      minLen = mps[AW-1:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [15:0] maxPkt_q;
  logic [15:0] layout_q;
  logic autoReady_q;
  logic halt_q;
  logic periodic_q;
  logic feedback_q;
  logic dataPid1_q;
  logic enPrev_q;
  logic [AW-1:0] wrCnt_q;
  logic [AW-1:0] len_q [2];
  logic [AW-1:0] sentOff_q;
  logic [AW-1:0] cnt_q;
  logic [AW-1:0] chunk_q;
  logic issue_q;
  logic issueLast_q;
  tx_state_t state_q;

  logic [1:0] fill;
  logic wrBuf;
  logic rdBuf;
  logic [7:0] ramData;
  logic [AW-1:0] rdAddr;

  logic dbl;
  logic cont;
  logic [AW-1:0] base;
  logic [AW-1:0] bufBytes;
  logic [AW-1:0] target;
  logic ctrlWr;
  logic dataWr;
  logic autoHit;
  logic prepare;
  logic sent;
  logic enRise;
  logic seqReset;
  logic [AW-1:0] rest;
  logic [AW-1:0] chunkNow;

  assign dbl = layout_q[usb_in_pkg::DBL_BIT];
  assign cont = layout_q[usb_in_pkg::CONT_BIT];
  assign base = AW'({layout_q[usb_in_pkg::START_LSB +: usb_in_pkg::START_W],
                     usb_in_pkg::BLOCK_SHIFT'(0)});
  assign bufBytes = AW'({layout_q[usb_in_pkg::LEN_LSB +: usb_in_pkg::LEN_W],
                         usb_in_pkg::BLOCK_SHIFT'(0)});
  assign target = cont ? bufBytes : maxPkt_q[AW-1:0];
  assign ctrlWr = regReq.wr && regReq.addr == usb_in_pkg::OFF_CTRL;
  // Bytes beyond the buffer or into a full FIFO are dropped; they would
  // otherwise corrupt a neighbour's region or a pending packet.
  assign dataWr = regReq.wr && regReq.addr == usb_in_pkg::OFF_DATA &&
                  fill != usb_in_pkg::FILL_FULL && wrCnt_q < bufBytes;
  assign autoHit = dataWr && autoReady_q && (wrCnt_q + AW'(1) == target);
  assign prepare = fill != usb_in_pkg::FILL_FULL && enPrev_q &&
                   ((ctrlWr && regReq.wdata[usb_in_pkg::READY_BIT]) || autoHit);
  assign seqReset = ctrlWr && regReq.wdata[usb_in_pkg::SEQRST_BIT];
  assign enRise = epEnable && !enPrev_q;
  assign rest = len_q[rdBuf] - sentOff_q;
  assign chunkNow = cont ? minLen(maxPkt_q, rest) : len_q[rdBuf];
  assign sent = state_q == ST_WAIT && ackRcvd &&
                (!cont || sentOff_q + chunk_q >= len_q[rdBuf]);

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes.

  always_ff @(posedge clock) begin
    if (reset) begin
      maxPkt_q <= usb_in_pkg::MAX_PKT_RESET;
      layout_q <= usb_in_pkg::LAYOUT_RESET;
    end else if (regReq.wr && regReq.addr == usb_in_pkg::OFF_MAX_PKT) begin
      maxPkt_q <= regReq.wdata;
    end else if (regReq.wr && regReq.addr == usb_in_pkg::OFF_LAYOUT) begin
      layout_q <= regReq.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      autoReady_q <= 1'b0;
      halt_q <= 1'b0;
      periodic_q <= 1'b0;
      feedback_q <= 1'b0;
    end else if (ctrlWr) begin
      autoReady_q <= regReq.wdata[usb_in_pkg::AUTO_BIT];
      halt_q <= regReq.wdata[usb_in_pkg::HALT_BIT];
      periodic_q <= regReq.wdata[usb_in_pkg::PERIODIC_BIT];
      feedback_q <= regReq.wdata[usb_in_pkg::FEEDBACK_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      enPrev_q <= 1'b0;
    end else begin
      enPrev_q <= epEnable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write side of the FIFO: hidden byte pointer and stored packet lengths.

  always_ff @(posedge clock) begin
    if (reset || enRise || seqReset) begin
      wrCnt_q <= '0;
    end else if (prepare) begin
      wrCnt_q <= '0;
    end else if (dataWr) begin
      wrCnt_q <= wrCnt_q + AW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      len_q[0] <= '0;
      len_q[1] <= '0;
    end else if (prepare) begin
      len_q[wrBuf] <= wrCnt_q + (dataWr ? AW'(1) : AW'(0));
    end
  end

  fill_tracker tracker (
    .clock(clock),
    .reset(reset),
    .dbl(dbl),
    .enRise(enRise),
    .ptrInit(seqReset),
    .prepare(prepare),
    .sent(sent),
    .fill(fill),
    .wrBuf(wrBuf),
    .rdBuf(rdBuf)
  );

  assign rdAddr = bufAddr(base, bufBytes, rdBuf, sentOff_q + cnt_q);

  in_buffer_ram ram (
    .clock(clock),
    .wrEn(dataWr),
    .wrAddr(bufAddr(base, bufBytes, wrBuf, wrCnt_q)),
    .wrData(regReq.wdata[7:0]),
    .rdAddr(rdAddr),
    .rdData(ramData)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // IN token handling.

  always_ff @(posedge clock) begin
    if (reset || enRise) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      chunk_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (inToken && epEnable && !halt_q && fill != usb_in_pkg::FILL_EMPTY) begin
            chunk_q <= chunkNow;
            state_q <= (chunkNow == '0) ? ST_WAIT : ST_SEND;
          end
        end
        ST_SEND: begin
          cnt_q <= cnt_q + AW'(1);
          if (cnt_q + AW'(1) == chunk_q) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ackRcvd || noAck) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Offset within the current buffer; only continuous mode moves it.
  always_ff @(posedge clock) begin
    if (reset || enRise || seqReset) begin
      sentOff_q <= '0;
    end else if (sent) begin
      sentOff_q <= '0;
    end else if (state_q == ST_WAIT && ackRcvd) begin
      sentOff_q <= sentOff_q + chunk_q;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || seqReset) begin
      dataPid1_q <= 1'b0;
    end else if (state_q == ST_WAIT && ackRcvd) begin
      dataPid1_q <= ~dataPid1_q;
    end
  end

  // Memory read takes one cycle, so byte flags trail the address by one.
  always_ff @(posedge clock) begin
    if (reset) begin
      issue_q <= 1'b0;
      issueLast_q <= 1'b0;
    end else begin
      issue_q <= state_q == ST_SEND;
      issueLast_q <= state_q == ST_SEND && cnt_q + AW'(1) == chunk_q;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      txOut <= '0;
    end else begin
      txOut.valid <= issue_q || (state_q == ST_IDLE && inToken && epEnable &&
                     !halt_q && fill != usb_in_pkg::FILL_EMPTY && chunkNow == '0);
      txOut.last <= issueLast_q || state_q == ST_IDLE;
      txOut.empty <= !issue_q;
      txOut.pidData1 <= dataPid1_q;
      txOut.data <= issue_q ? ramData : 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      handshake <= '0;
    end else begin
      handshake.valid <= state_q == ST_IDLE && inToken && epEnable &&
                         (halt_q || fill == usb_in_pkg::FILL_EMPTY);
      handshake.stall <= halt_q;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      inIrq <= 1'b0;
    end else begin
      inIrq <= state_q == ST_WAIT && ackRcvd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads.

  always_ff @(posedge clock) begin
    if (reset) begin
      regRdata <= 16'h0000;
    end else if (regReq.rd) begin
      case (regReq.addr)
        usb_in_pkg::OFF_MAX_PKT: regRdata <= maxPkt_q;
        usb_in_pkg::OFF_LAYOUT: regRdata <= layout_q;
        usb_in_pkg::OFF_CTRL: begin
          regRdata <= 16'h0000;
          regRdata[usb_in_pkg::AUTO_BIT] <= autoReady_q;
          regRdata[usb_in_pkg::HALT_BIT] <= halt_q;
          regRdata[usb_in_pkg::PERIODIC_BIT] <= periodic_q;
          regRdata[usb_in_pkg::FEEDBACK_BIT] <= feedback_q;
          regRdata[usb_in_pkg::FILL_LSB +: 2] <= fill;
        end
        default: regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence idleToken;
    state_q == ST_IDLE && inToken && epEnable;
  endsequence

  sequence ackInWait;
    state_q == ST_WAIT && ackRcvd;
  endsequence

  halt_stall_a: assert property (@(posedge clock) disable iff (reset)
    idleToken ##0 halt_q |=> handshake.valid && handshake.stall)
    else $error("halted endpoint did not stall");

  empty_nak_a: assert property (@(posedge clock) disable iff (reset)
    idleToken ##0 (!halt_q && fill == usb_in_pkg::FILL_EMPTY)
      |=> handshake.valid && !handshake.stall && !txOut.valid)
    else $error("empty endpoint did not answer NAK");

  ack_toggle_a: assert property (@(posedge clock) disable iff (reset)
    ackInWait ##0 !seqReset |=> dataPid1_q != $past(dataPid1_q) && inIrq)
    else $error("ACK did not toggle PID and raise interrupt");

  noack_keep_a: assert property (@(posedge clock) disable iff (reset)
    state_q == ST_WAIT && noAck && !seqReset && !prepare && !enRise
      |=> $stable(dataPid1_q) && $stable(fill) && $stable(sentOff_q))
    else $error("missing ACK changed packet state");

  single_ready_a: assert property (@(posedge clock) disable iff (reset)
    !dbl && prepare && !enRise && fill == usb_in_pkg::FILL_EMPTY
      |=> fill == usb_in_pkg::FILL_FULL)
    else $error("single buffer ready did not fill");

  double_ready_a: assert property (@(posedge clock) disable iff (reset)
    dbl && prepare && !sent && !enRise && fill == usb_in_pkg::FILL_EMPTY
      |=> fill == usb_in_pkg::FILL_ONE)
    else $error("double buffer first ready wrong");

  enable_clear_a: assert property (@(posedge clock) disable iff (reset)
    enRise |=> fill == usb_in_pkg::FILL_EMPTY)
    else $error("enable did not clear fill state");

  seq_reset_a: assert property (@(posedge clock) disable iff (reset)
    seqReset |=> !dataPid1_q ##0 $past(seqReset))
    else $error("sequence reset did not give DATA0");

  single_sent_a: assert property (@(posedge clock) disable iff (reset)
    !dbl && sent && !enRise |=> fill == usb_in_pkg::FILL_EMPTY)
    else $error("single buffer send did not empty");

  auto_ready_a: assert property (@(posedge clock) disable iff (reset)
    autoHit && fill != usb_in_pkg::FILL_FULL && enPrev_q && !enRise && !sent
      |=> fill != $past(fill) && wrCnt_q == '0)
    else $error("auto ready did not prepare packet");
endmodule
`default_nettype wire

// ---- hdl/usb_in_pkg.sv ----
// Purpose: Shared constants and carrier types for the IN endpoint transmit block.
// Assumes: 50 MHz system clock; 16-bit register port with byte-wide FIFO data writes.
// Notes: Register offsets are byte addresses on the plain register port.
package usb_in_pkg;
  // Register offsets.
  localparam logic [3:0] OFF_MAX_PKT = 4'h0;
  localparam logic [3:0] OFF_LAYOUT = 4'h4;
  localparam logic [3:0] OFF_CTRL = 4'h8;
  localparam logic [3:0] OFF_DATA = 4'hc;
  // Reset values.
  localparam logic [15:0] MAX_PKT_RESET = 16'h0000;
  localparam logic [15:0] LAYOUT_RESET = 16'h0000;
  // Layout register fields.
  localparam int START_LSB = 0;
  localparam int START_W = 6;
  localparam int LEN_LSB = 6;
  localparam int LEN_W = 4;
  localparam int DBL_BIT = 10;
  localparam int CONT_BIT = 11;
  // Control and status register fields.
  localparam int READY_BIT = 0;
  localparam int SEQRST_BIT = 1;
  localparam int AUTO_BIT = 2;
  localparam int HALT_BIT = 3;
  localparam int PERIODIC_BIT = 4;
  localparam int FEEDBACK_BIT = 5;
  localparam int FILL_LSB = 8;
  // Buffer memory geometry: 64-byte blocks in a 3072-byte shared memory.
  localparam int BLOCK_SHIFT = 6;
  localparam int MEM_BYTES = 3072;
  localparam int ADDR_W = 12;
  // Fill-state codes.
  localparam logic [1:0] FILL_EMPTY = 2'h0;
  localparam logic [1:0] FILL_ONE = 2'h1;
  localparam logic [1:0] FILL_FULL = 2'h3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic empty;
    logic pidData1;
    logic [7:0] data;
  } tx_byte_t;

  typedef struct packed {
    logic valid;
    logic stall;
  } handshake_t;
endpackage
